/* mdqs_regs.svh */
// Register offsets, field positions and reset values of the MAC DMA queue and status block
// Summary of operation
// - Collision sets tx collision flag, W1C
// - Used descriptor fetch sets tx used flag
// - Status write one clears, never sets
// - Rx pointer write loads start, read current
// - Pointer advances per buffer, wraps 1024/wrap
// - Tx pointer write ignored while transmitting
// - Tx pointer reads current frame's first descriptor
// - Rx overrun flag set, buffer recovered
// - Frame stored sets frame received flag
// - Every failed buffer fetch sets no-buffer
// - Reading interrupt flags clears all but same-cycle sets
// - Pause countdown zero sets bit 13
// - Valid pause frame sets bit 12
// - Bus error response sets bit 11
// - Interrupt flag layout bits 13..10, 7..0
// - Rx overrun status sets overrun interrupt
// - Three causes set tx underrun interrupt
// - Management done sets bit 0
`ifndef MDQS_REGS_SVH
`define MDQS_REGS_SVH
`define MDQS_OFF_TXST     8'h14
`define MDQS_OFF_RXQ      8'h18
`define MDQS_OFF_TXQ      8'h1C
`define MDQS_OFF_RXST     8'h20
`define MDQS_OFF_IRQ      8'h24
`define MDQS_TXST_USED    0
`define MDQS_TXST_COL     1
`define MDQS_TXST_RETRY   2
`define MDQS_TXST_ACT     3
`define MDQS_TXST_BEX     4
`define MDQS_TXST_COMP    5
`define MDQS_TXST_UND     6
`define MDQS_RXST_NOBUF   0
`define MDQS_RXST_FRAME   1
`define MDQS_RXST_OVER    2
`define MDQS_IRQ_MGMT     0
`define MDQS_IRQ_RXDONE   1
`define MDQS_IRQ_RXUSED   2
`define MDQS_IRQ_TXUSED   3
`define MDQS_IRQ_TXUND    4
`define MDQS_IRQ_RETRY    5
`define MDQS_IRQ_TXFAULT  6
`define MDQS_IRQ_TXDONE   7
`define MDQS_IRQ_RXOVER   10
`define MDQS_IRQ_BUSERR   11
`define MDQS_IRQ_PAUSERX  12
`define MDQS_IRQ_PAUSEZ   13
`define MDQS_RST_WORD  32'h00000000
`define MDQS_DESC_NUM  1024
`endif

/* mdqs_pkg.sv */
// Types shared by the MAC DMA queue and status block
package mdqs_pkg;
  typedef logic [31:0] mdqs_word_t;  // Register bus word
  typedef logic [29:0] mdqs_waddr_t; // Word address of a descriptor
  typedef logic [9:0]  mdqs_idx_t;   // Descriptor index in a queue
endpackage : mdqs_pkg

/* mdqs_top.sv */
// MAC DMA descriptor queue pointers and transmit, receive and interrupt status flags
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "mdqs_regs.svh"
module mdqs_top
  import mdqs_pkg::*;
#(
  parameter int DESC_NUM = `MDQS_DESC_NUM
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        tx_active,
  input  wire logic        tx_collision,
  input  wire logic        tx_used_seen,
  input  wire logic        tx_underrun_evt,
  input  wire logic        tx_done_evt,
  input  wire logic        tx_error_evt,
  input  wire logic        retry_limit_evt,
  input  wire logic        tx_buf_consumed,
  input  wire logic        tx_wrap,
  input  wire logic        rx_overrun_evt,
  input  wire logic        rx_frame_stored,
  input  wire logic        rx_no_buffer_evt,
  input  wire logic        rx_buf_consumed,
  input  wire logic        rx_wrap,
  input  wire logic        pause_zero_evt,
  input  wire logic        pause_rx_evt,
  input  wire logic        bus_error_evt,
  input  wire logic        mgmt_done_evt,
  output var  logic [31:0] rx_desc_addr,
  output var  logic [31:0] tx_desc_addr
);

  // Index counters are 10 bits wide, so deeper queues cannot be served
  if (DESC_NUM < 2 || DESC_NUM > `MDQS_DESC_NUM) begin : g_bad_depth
    $error("DESC_NUM out of range");
  end

  localparam mdqs_idx_t IDX_LAST = mdqs_idx_t'(DESC_NUM - 1);

  // Next descriptor index after one buffer is used up
  function automatic mdqs_idx_t step_idx(input mdqs_idx_t idx, input logic wrap);
    if (wrap || idx == IDX_LAST) begin
      step_idx = '0;
    end else begin
      step_idx = idx + 10'h001;
    end
  endfunction : step_idx

  // Descriptor byte address: two words per descriptor above the loaded start
  function automatic mdqs_word_t desc_addr(input mdqs_waddr_t base, input mdqs_idx_t idx);
    mdqs_waddr_t w;
    w = base + mdqs_waddr_t'({idx, 1'b0});
    desc_addr = {w, 2'b00};
  endfunction : desc_addr

  // Register bus decode
  logic wr_txst;           // Write to tx status
  logic wr_rxst;           // Write to rx status
  logic wr_rxq;            // Write to rx pointer
  logic wr_txq;            // Accepted write to tx pointer
  logic rd_irq;            // Read of interrupt flags
  assign wr_txst = reg_wr && reg_addr == `MDQS_OFF_TXST;
  assign wr_rxst = reg_wr && reg_addr == `MDQS_OFF_RXST;
  assign wr_rxq  = reg_wr && reg_addr == `MDQS_OFF_RXQ;
  assign wr_txq  = reg_wr && reg_addr == `MDQS_OFF_TXQ && !tx_active;
  assign rd_irq  = reg_rd && reg_addr == `MDQS_OFF_IRQ;

  // Queue pointer state
  mdqs_waddr_t rx_base;    // Loaded rx queue start
  mdqs_idx_t   rx_idx;     // Current rx descriptor
  mdqs_waddr_t tx_base;    // Loaded tx queue start
  mdqs_idx_t   tx_idx;     // Current tx descriptor
  mdqs_idx_t   tx_first;   // First descriptor of current frame
  mdqs_waddr_t next_rx_base;
  mdqs_idx_t   next_rx_idx;
  mdqs_waddr_t next_tx_base;
  mdqs_idx_t   next_tx_idx;
  mdqs_idx_t   next_tx_first;

  // Pointer next values; a load wins over a buffer used up in the same cycle
  always_comb begin
    next_rx_base  = rx_base;
    next_rx_idx   = rx_idx;
    next_tx_base  = tx_base;
    next_tx_idx   = tx_idx;
    next_tx_first = tx_first;
    // Overrun buffer is recovered, so the pointer stays put
    if (wr_rxq) begin
      next_rx_base = reg_wdata[31:2];
      next_rx_idx  = '0;
    end else if (rx_buf_consumed && !rx_overrun_evt) begin
      next_rx_idx = step_idx(rx_idx, rx_wrap);
    end
    // Tx pointer only moves by software while idle
    if (wr_txq) begin
      next_tx_base  = reg_wdata[31:2];
      next_tx_idx   = '0;
      next_tx_first = '0;
    end else begin
      if (tx_buf_consumed) begin
        next_tx_idx = step_idx(tx_idx, tx_wrap);
      end
      // Frame done: next frame starts at the following descriptor
      if (tx_done_evt) begin
        next_tx_first = next_tx_idx;
      end
    end
  end

  // Pointer registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_base  <= '0;
      rx_idx   <= '0;
      tx_base  <= '0;
      tx_idx   <= '0;
      tx_first <= '0;
    end else begin
      rx_base  <= next_rx_base;
      rx_idx   <= next_rx_idx;
      tx_base  <= next_tx_base;
      tx_idx   <= next_tx_idx;
      tx_first <= next_tx_first;
    end
  end

  // Addresses handed to the DMA engines
  always_comb begin
    rx_desc_addr = desc_addr(rx_base, rx_idx);
    tx_desc_addr = desc_addr(tx_base, tx_idx);
  end

  // Status flags
  logic [6:0]  tx_status;  // Tx status, bit 3 unused (live level)
  logic [2:0]  rx_status;  // Rx status
  logic [13:0] irq_flags;  // Interrupt flags, bits 9:8 stay zero
  logic [6:0]  next_tx_status;
  logic [2:0]  next_rx_status;
  logic [13:0] next_irq_flags;
  logic [6:0]  tx_set;     // Tx status set events
  logic [2:0]  rx_set;     // Rx status set events
  logic [13:0] irq_set;    // Interrupt set events

  // Set events; a set always wins over any clear in the same cycle
  always_comb begin
    tx_set = '0;
    tx_set[`MDQS_TXST_USED]  = tx_used_seen;
    tx_set[`MDQS_TXST_COL]   = tx_collision;
    tx_set[`MDQS_TXST_RETRY] = retry_limit_evt;
    tx_set[`MDQS_TXST_BEX]   = tx_error_evt;
    tx_set[`MDQS_TXST_COMP]  = tx_done_evt;
    tx_set[`MDQS_TXST_UND]   = tx_underrun_evt;
    rx_set = '0;
    rx_set[`MDQS_RXST_NOBUF] = rx_no_buffer_evt;
    rx_set[`MDQS_RXST_FRAME] = rx_frame_stored;
    rx_set[`MDQS_RXST_OVER]  = rx_overrun_evt;
    irq_set = '0;
    irq_set[`MDQS_IRQ_MGMT]    = mgmt_done_evt;
    irq_set[`MDQS_IRQ_RXDONE]  = rx_frame_stored;
    irq_set[`MDQS_IRQ_RXUSED]  = rx_no_buffer_evt;
    irq_set[`MDQS_IRQ_TXUSED]  = tx_used_seen;
    irq_set[`MDQS_IRQ_TXUND]   = tx_underrun_evt || (bus_error_evt && tx_active) || wr_txq;
    irq_set[`MDQS_IRQ_RETRY]   = retry_limit_evt;
    irq_set[`MDQS_IRQ_TXFAULT] = tx_error_evt;
    irq_set[`MDQS_IRQ_TXDONE]  = tx_done_evt;
    irq_set[`MDQS_IRQ_RXOVER]  = rx_overrun_evt;
    irq_set[`MDQS_IRQ_BUSERR]  = bus_error_evt;
    irq_set[`MDQS_IRQ_PAUSERX] = pause_rx_evt;
    irq_set[`MDQS_IRQ_PAUSEZ]  = pause_zero_evt;
  end

  // Flag next values: write one clears, read clears the interrupt flags
  always_comb begin
    next_tx_status = tx_status;
    next_rx_status = rx_status;
    next_irq_flags = irq_flags;
    if (wr_txst) begin
      next_tx_status = tx_status & ~reg_wdata[6:0];
    end
    if (wr_rxst) begin
      next_rx_status = rx_status & ~reg_wdata[2:0];
    end
    if (rd_irq) begin
      next_irq_flags = '0;
    end
    next_tx_status = next_tx_status | tx_set;
    next_rx_status = next_rx_status | rx_set;
    next_irq_flags = next_irq_flags | irq_set;
    next_tx_status[`MDQS_TXST_ACT] = 1'b0;
  end

  // Flag registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_status <= '0;
      rx_status <= '0;
      irq_flags <= '0;
    end else begin
      tx_status <= next_tx_status;
      rx_status <= next_rx_status;
      irq_flags <= next_irq_flags;
    end
  end

  // Read data: valid the cycle after the strobe, zero otherwise
  mdqs_word_t next_rdata;
  always_comb begin
    next_rdata = '0;
    if (!reg_rd) begin
      next_rdata = '0;
    end else if (reg_addr == `MDQS_OFF_TXST) begin
      next_rdata = {25'h0000000, tx_status[6:4], tx_active, tx_status[2:0]};
    end else if (reg_addr == `MDQS_OFF_RXQ) begin
      next_rdata = desc_addr(rx_base, rx_idx);
    end else if (reg_addr == `MDQS_OFF_TXQ) begin
      next_rdata = desc_addr(tx_base, tx_first);
    end else if (reg_addr == `MDQS_OFF_RXST) begin
      next_rdata = {29'h00000000, rx_status};
    end else if (reg_addr == `MDQS_OFF_IRQ) begin
      next_rdata = {18'h00000, irq_flags};
    end
  end

  // Read data register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `MDQS_RST_WORD;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Busy transmitter keeps its queue start
  tx_lock_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && reg_addr == `MDQS_OFF_TXQ && tx_active) |=> $stable(tx_base))
    else $error("tx pointer changed while active");

  // Rx status write never raises a bit
  rxst_noset_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_rxst && rx_set == 3'h0) |=> (rx_status & ~$past(rx_status)) == 3'h0)
    else $error("rx status bit set by a write");

  // Read clears the interrupt flags
  irq_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rd_irq && irq_set == 14'h0000) |=> irq_flags == 14'h0000)
    else $error("interrupt flags not cleared by read");

  // Pause zero survives a clearing read
  irq_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    pause_zero_evt |=> irq_flags[`MDQS_IRQ_PAUSEZ])
    else $error("pause zero flag lost");

  // Collision beats a clearing write
  col_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    tx_collision |=> tx_status[`MDQS_TXST_COL] ##1 (tx_status[`MDQS_TXST_COL] || $past(wr_txst)))
    else $error("collision flag lost");

  // Every failed fetch marks no buffer
  nobuf_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    rx_no_buffer_evt |=> rx_status[`MDQS_RXST_NOBUF] && irq_flags[`MDQS_IRQ_RXUSED])
    else $error("no-buffer flag not set");

  // Rx pointer wraps to the loaded start
  rx_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rx_buf_consumed && rx_wrap && !rx_overrun_evt && !wr_rxq) |=> rx_idx == 10'h000)
    else $error("rx pointer did not wrap");

  // Rx pointer steps one descriptor per buffer
  rx_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rx_buf_consumed && !rx_wrap && !rx_overrun_evt && !wr_rxq && rx_idx != IDX_LAST)
    |=> rx_desc_addr == $past(rx_desc_addr) + 32'h00000008)
    else $error("rx pointer step wrong");

  // Rx pointer read returns the loaded start
  rx_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_rxq ##1 (reg_rd && reg_addr == `MDQS_OFF_RXQ && !rx_buf_consumed)
    |=> reg_rdata == {$past(reg_wdata[31:2], 2), 2'b00})
    else $error("rx pointer read wrong");

  // Accepted tx pointer write flags underrun
  underrun_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_txq |=> irq_flags[`MDQS_IRQ_TXUND])
    else $error("tx underrun not flagged");

  // Used descriptor fetch marks status and interrupt
  used_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    tx_used_seen |=> tx_status[`MDQS_TXST_USED] && irq_flags[`MDQS_IRQ_TXUSED])
    else $error("tx used flag not set");

  // Stored frame marks status and interrupt
  frame_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    rx_frame_stored |=> rx_status[`MDQS_RXST_FRAME] && irq_flags[`MDQS_IRQ_RXDONE])
    else $error("frame received flag not set");

  // Overrun status comes with its interrupt
  overrun_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    rx_overrun_evt |=> rx_status[`MDQS_RXST_OVER] && irq_flags[`MDQS_IRQ_RXOVER])
    else $error("overrun flag not set");

  // Bus error response marks its interrupt
  bus_err_a: assert property (@(posedge mclk) disable iff (!resetn)
    bus_error_evt |=> irq_flags[`MDQS_IRQ_BUSERR])
    else $error("bus error flag not set");

endmodule : mdqs_top
`default_nettype wire

/* mdqs_mem_model.sv */
// Behavioural descriptor memory handing buffers to the queue logic
`timescale 1ns/1ns
`default_nettype none
module mdqs_mem_model #(
  parameter logic [31:0] RX_WRAP_AT = 32'h00001008, // Rx descriptor holding a wrap mark
  parameter logic [31:0] TX_WRAP_AT = 32'hFFFFFFF8  // Tx wrap mark kept out of reach
) (
  input  wire logic        mclk,
  input  wire logic        rx_take,
  input  wire logic        tx_take,
  input  wire logic [31:0] rx_desc_addr,
  input  wire logic [31:0] tx_desc_addr,
  output var  logic        rx_buf_consumed,
  output var  logic        rx_wrap,
  output var  logic        tx_buf_consumed,
  output var  logic        tx_wrap
);
  logic junk; // Toggles so an unsampled wrap line never looks steady
  // Free-running junk pattern
  initial junk = 1'b0;
  always @(posedge mclk) junk <= ~junk;
  // Wrap mark valid only beside a hand-over; otherwise rx carries the junk pattern and tx its inverse
  always_comb begin
    rx_buf_consumed = rx_take;
    tx_buf_consumed = tx_take;
    rx_wrap = rx_take ? (rx_desc_addr == RX_WRAP_AT) : junk;
    tx_wrap = tx_take ? (tx_desc_addr == TX_WRAP_AT) : ~junk;
  end
endmodule : mdqs_mem_model
`default_nettype wire

/* testbench.sv */
// Self-checking testbench of the MAC DMA queue and status block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mdqs_pkg::*;
  localparam int NDESC = 4; // Short queue so the full-count wrap comes quickly
  logic        mclk, resetn, reg_wr, reg_rd, tx_active, rx_take, tx_take;
  logic [7:0]  reg_addr;
  mdqs_word_t  reg_wdata, reg_rdata, rx_desc_addr, tx_desc_addr;
  logic [12:0] ev; // Event pulses, one bit per source
  logic        rx_buf_consumed, rx_wrap, tx_buf_consumed, tx_wrap;
  int          num_errors = 0;
  int          n_checks = 0;
  // Status offset, status bit and interrupt bit per event; -1 means none
  localparam logic [7:0] SOFF [13] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h20,
                                       8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int SBIT [13] = '{1, 0, 6, 5, 4, 2, 2, 1, 0, -1, -1, -1, -1};
  localparam int IBIT [13] = '{-1, 3, 4, 7, 6, 5, 10, 1, 2, 13, 12, 11, 0};

  mdqs_top #(.DESC_NUM(NDESC)) i_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_active(tx_active), .tx_collision(ev[0]), .tx_used_seen(ev[1]),
    .tx_underrun_evt(ev[2]), .tx_done_evt(ev[3]), .tx_error_evt(ev[4]),
    .retry_limit_evt(ev[5]), .tx_buf_consumed(tx_buf_consumed), .tx_wrap(tx_wrap),
    .rx_overrun_evt(ev[6]), .rx_frame_stored(ev[7]), .rx_no_buffer_evt(ev[8]),
    .rx_buf_consumed(rx_buf_consumed), .rx_wrap(rx_wrap), .pause_zero_evt(ev[9]),
    .pause_rx_evt(ev[10]), .bus_error_evt(ev[11]), .mgmt_done_evt(ev[12]),
    .rx_desc_addr(rx_desc_addr), .tx_desc_addr(tx_desc_addr));
  mdqs_mem_model i_mem (.mclk(mclk), .rx_take(rx_take), .tx_take(tx_take),
    .rx_desc_addr(rx_desc_addr), .tx_desc_addr(tx_desc_addr),
    .rx_buf_consumed(rx_buf_consumed), .rx_wrap(rx_wrap),
    .tx_buf_consumed(tx_buf_consumed), .tx_wrap(tx_wrap));

  task automatic chk(input string what, input mdqs_word_t got, input mdqs_word_t exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle write strobe, then one idle edge so calls never meet in a time step
  task automatic wr(input logic [7:0] a, input mdqs_word_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  // One-cycle read strobe; data stand until the next edge and are taken there
  task automatic rdchk(input logic [7:0] a, input mdqs_word_t exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(what, reg_rdata, exp);
  endtask : rdchk
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev <= '0;
    @(posedge mclk);
  endtask : pulse
  // Ask the memory model for one buffer of either queue, optionally beside an event
  task automatic take(input bit tx, input int evi = -1);
    if (tx) tx_take <= 1'b1;
    else rx_take <= 1'b1;
    if (evi >= 0) ev[evi] <= 1'b1;
    @(posedge mclk);
    tx_take <= 1'b0;
    rx_take <= 1'b0;
    ev <= '0;
    @(posedge mclk);
  endtask : take
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic t_reset();
    for (int a = 8'h14; a <= 8'h24; a += 4) rdchk(a[7:0], 32'h0, "reset value");
    wr(8'h40, 32'hFFFFFFFF);
    rdchk(8'h40, 32'h0, "unmapped");
  endtask : t_reset
  // Every event source: flag and irq bit where it has them, clear-on-read, one-to-clear
  task automatic t_flags();
    mdqs_word_t sm, im;
    for (int i = 0; i < 13; i++) begin
      sm = (SBIT[i] < 0) ? 32'h0 : 32'h1 << SBIT[i];
      im = (IBIT[i] < 0) ? 32'h0 : 32'h1 << IBIT[i];
      pulse(i);
      rdchk(8'h24, im, "irq flags");
      rdchk(8'h24, 32'h0, "irq cleared");
      if (SBIT[i] >= 0) begin
        wr(SOFF[i], ~sm);
        rdchk(SOFF[i], sm, "status kept");
        wr(SOFF[i], sm);
        rdchk(SOFF[i], 32'h0, "status cleared");
      end
    end
  endtask : t_flags
  task automatic t_races();
    pulse(8);
    rdchk(8'h24, 32'h4, "no buffer first");
    wr(8'h20, 32'h1);
    pulse(8);
    rdchk(8'h20, 32'h1, "no buffer again");
    rdchk(8'h24, 32'h4, "no buffer irq again");
    wr(8'h20, 32'h1);
    // Pause event in the same edge as a clearing read
    ev[9] <= 1'b1;
    reg_addr <= 8'h24;
    reg_rd <= 1'b1;
    @(posedge mclk);
    ev <= '0;
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk("read beside event", reg_rdata, 32'h0);
    rdchk(8'h24, 32'h2000, "event beside read");
    // Frame event in the same edge as a clearing write
    ev[7] <= 1'b1;
    reg_addr <= 8'h20;
    reg_wdata <= 32'h2;
    reg_wr <= 1'b1;
    @(posedge mclk);
    ev <= '0;
    reg_wr <= 1'b0;
    @(posedge mclk);
    rdchk(8'h20, 32'h2, "set beats clear");
    wr(8'h20, 32'h2);
    rdchk(8'h20, 32'h0, "frame cleared");
    rdchk(8'h24, 32'h2, "frame irq");
  endtask : t_races
  task automatic t_rx_ptr();
    wr(8'h18, 32'h00001003);
    rdchk(8'h18, 32'h1000, "rx load");
    chk("rx addr out", rx_desc_addr, 32'h1000);
    take(1'b0);
    rdchk(8'h18, 32'h1008, "rx step");
    take(1'b0, 6);
    rdchk(8'h18, 32'h1008, "rx overrun hold");
    take(1'b0);
    rdchk(8'h18, 32'h1000, "rx wrap mark");
    wr(8'h20, 32'h4);
    rdchk(8'h24, 32'h400, "overrun irq");
  endtask : t_rx_ptr
  task automatic t_tx_ptr();
    wr(8'h1C, 32'h00002000);
    rdchk(8'h24, 32'h10, "reload underrun");
    repeat (2) take(1'b1);
    chk("tx addr out", tx_desc_addr, 32'h2010);
    rdchk(8'h1C, 32'h2000, "tx frame start");
    pulse(3);
    rdchk(8'h1C, 32'h2010, "tx next frame");
    repeat (2) take(1'b1);
    chk("tx full count", tx_desc_addr, 32'h2000);
    tx_active <= 1'b1;
    wr(8'h1C, 32'h00003000);
    rdchk(8'h14, 32'h28, "tx active");
    rdchk(8'h1C, 32'h2010, "tx locked");
    rdchk(8'h24, 32'h80, "no reload irq");
    pulse(11);
    rdchk(8'h24, 32'h810, "bus error active");
    tx_active <= 1'b0;
  endtask : t_tx_ptr

  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Hang guard
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_active = 1'b0;
    rx_take = 1'b0;
    tx_take = 1'b0;
    ev = '0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_flags();
    t_races();
    t_rx_ptr();
    t_tx_ptr();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
